// ==== src/uart_serial_port_defines.vh ====
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef UART_SERIAL_PORT_DEFINES_VH
`define UART_SERIAL_PORT_DEFINES_VH
`define OFF_DATA 12'h000
`define OFF_IRQ_EN 12'h004
`define OFF_IRQ_ID 12'h008
`define OFF_LINE_CTRL 12'h00C
`define OFF_LINE_STAT 12'h014
`define OFF_MOD_STAT 12'h07C
`define LC_DIV_ACCESS 7
`define LC_BREAK 6
`define LC_EVEN_PAR 4
`define LC_PAR_EN 3
`define LC_STOP2 2
`define IE_THRESH_MODE 7
`define IE_MODEM 3
`define IE_LINE 2
`define IE_TX_EMPTY 1
`define IE_RX_DATA 0
`define LS_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2
`define LS_FRAME 3
`define LS_HOLD_EMPTY 5
`define LS_IDLE 6
`define CODE_MODEM 4'h0
`define CODE_NONE 4'h1
`define CODE_TX_EMPTY 4'h2
`define CODE_RX_DATA 4'h4
`define CODE_LINE 4'h6
`define CODE_BUSY 4'h7
`define CODE_TIMEOUT 4'hC
`define FIFO_STAT_OFF 2'h0
`define FIFO_STAT_ON 2'h3
`define OVERSAMPLE 16
`define DIV_RESET 16'h0000
`define BAUD_MAX_BPS 1000000
`endif

// ==== src/uart_baud_gen.v ====
// Baud tick generator giving sixteen ticks per bit from a 16-bit divisor.
`timescale 1ns/10ps
`include "uart_serial_port_defines.vh"
module uart_baud_gen (
    // Clock and control.
    input wire clk,
    input wire rstn,
    input wire clkEn,
    // Divisor and tick.
    input wire [15:0] divisor,
    output reg tick16
);
    reg [15:0] count_q;

    // Counts the divisor down; a zero divisor stops the ticks.
    always @(posedge clk) begin
        if (!rstn) begin
            count_q <= 16'h0000;
            tick16 <= 1'b0;
        end else if (clkEn) begin
            tick16 <= 1'b0;
            if (divisor == 16'h0000) begin
                count_q <= 16'h0000;
            end else if (count_q <= 16'h0001) begin
                count_q <= divisor;
                tick16 <= 1'b1;
            end else begin
                count_q <= count_q - 16'h0001;
            end
        end
    end
endmodule

// ==== src/uart_serial_port.v ====
// Serial port with APB registers, framing, parity, flow control and interrupt identity.
`timescale 1ns/10ps
`include "uart_serial_port_defines.vh"
// Function
// - Full duplex serial with CTS/RTS flow
// - Parity generated and checked as ninth bit
// - Offset 0 read returns received character
// - Divisor bytes at 0/4, write when idle
// - Baud equals clock over sixteen times divisor
// - Enable register bit 7 stored but unused
// - Enable register bit 3 gates modem status
// - Enable register bit 2 gates line status
// - Enable register bit 1 gates transmit empty
// - Enable register bit 0 gates received data
// - Identity bits 7:6 always read 00, FIFO off
// - Identity bits 3:0 give top pending
// - Line control bit 7 selects divisor
module uart_serial_port (
    // Clock, reset and enable.
    input wire clk,
    input wire rstn,
    input wire clkEn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Serial pins.
    input wire rxd,
    input wire ctsN,
    output reg txd,
    output reg rtsN,
    // Interrupt identity level.
    output reg irqPending
);
    // =========================================================
    // Registers
    reg [7:0] lineCtrl_q;
    reg [7:0] irqEn_q;
    reg [15:0] div_q;
    reg [7:0] txHold_q;
    reg txFull_q;
    reg [7:0] rxBuf_q;
    reg dataReady_q;
    reg overrun_q;
    reg parityErr_q;
    reg frameErr_q;
    reg ctsChange_q;
    reg busyWrite_q;
    wire tick16;
    wire busy;

    // Two-flop synchronisers for the pins.
    reg rxS1_q;
    reg rxS2_q;
    reg ctsS1_q;
    reg ctsS2_q;
    reg ctsOld_q;
    always @(posedge clk) begin
        if (!rstn) begin
            rxS1_q <= 1'b1;
            rxS2_q <= 1'b1;
            ctsS1_q <= 1'b1;
            ctsS2_q <= 1'b1;
            ctsOld_q <= 1'b1;
        end else if (clkEn) begin
            rxS1_q <= rxd;
            rxS2_q <= rxS1_q;
            ctsS1_q <= ctsN;
            ctsS2_q <= ctsS1_q;
            ctsOld_q <= ctsS2_q;
        end
    end

    // Baud tick generator.
    uart_baud_gen baudGen (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .divisor(div_q),
        .tick16(tick16)
    );

    // Number of data bits after the start bit, parity included.
    function [3:0] frameBits;
        input pen;
        begin
            frameBits = pen ? 4'h9 : 4'h8;
        end
    endfunction

    // =========================================================
    // Transmitter
    reg [1:0] txState_q;
    reg [3:0] txTick_q;
    reg [3:0] txBit_q;
    reg [8:0] txShift_q;
    reg txStop_q;
    localparam TX_IDLE = 2'b00;
    localparam TX_START = 2'b01;
    localparam TX_DATA = 2'b10;
    localparam TX_STOP = 2'b11;
    wire txParity = lineCtrl_q[`LC_EVEN_PAR] ? ^txHold_q : ~^txHold_q;
    wire txTake;
    assign txTake = (txState_q == TX_IDLE) && txFull_q && !ctsS2_q && tick16;

    // Shifts start, data LSB first, parity and stop bits; waits for clear-to-send.
    always @(posedge clk) begin
        if (!rstn) begin
            txState_q <= TX_IDLE;
            txTick_q <= 4'h0;
            txBit_q <= 4'h0;
            txShift_q <= 9'h1FF;
            txStop_q <= 1'b0;
            txd <= 1'b1;
        end else if (clkEn) begin
            case (txState_q)
                TX_IDLE: begin
                    txd <= ~lineCtrl_q[`LC_BREAK];
                    if (txTake) begin
                        txShift_q <= {txParity, txHold_q};
                        txState_q <= TX_START;
                        txTick_q <= 4'h0;
                        txd <= 1'b0;
                    end
                end
                TX_START, TX_DATA: if (tick16) begin
                    txTick_q <= txTick_q + 4'h1;
                    if (txTick_q == 4'hF) begin
                        txd <= txShift_q[0] & ~lineCtrl_q[`LC_BREAK];
                        txShift_q <= {1'b1, txShift_q[8:1]};
                        if (txState_q == TX_START) begin
                            txState_q <= TX_DATA;
                            txBit_q <= frameBits(lineCtrl_q[`LC_PAR_EN]);
                        end else begin
                            txBit_q <= txBit_q - 4'h1;
                        end
                        if (txState_q == TX_DATA && txBit_q == 4'h1) begin
                            txState_q <= TX_STOP;
                            txStop_q <= lineCtrl_q[`LC_STOP2];
                            txd <= ~lineCtrl_q[`LC_BREAK];
                        end
                    end
                end
                TX_STOP: if (tick16) begin
                    txTick_q <= txTick_q + 4'h1;
                    if (txTick_q == 4'hF) begin
                        if (txStop_q) begin
                            txStop_q <= 1'b0;
                        end else begin
                            txState_q <= TX_IDLE;
                        end
                    end
                end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    // =========================================================
    // Receiver
    reg [1:0] rxState_q;
    reg [3:0] rxTick_q;
    reg [3:0] rxBit_q;
    reg [8:0] rxShift_q;
    reg rxDone_q;
    reg rxPerr_q;
    reg rxFerr_q;
    localparam RX_IDLE = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;
    wire [8:0] rxWord = lineCtrl_q[`LC_PAR_EN] ? rxShift_q : {1'b0, rxShift_q[8:1]};
    wire rxParityOk = lineCtrl_q[`LC_EVEN_PAR] ? ~^rxWord : ^rxWord;

    // Samples mid-bit, checks parity and stop bit, produces a one-cycle done pulse.
    always @(posedge clk) begin
        if (!rstn) begin
            rxState_q <= RX_IDLE;
            rxTick_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxShift_q <= 9'h000;
            rxDone_q <= 1'b0;
            rxPerr_q <= 1'b0;
            rxFerr_q <= 1'b0;
        end else if (clkEn) begin
            rxDone_q <= 1'b0;
            case (rxState_q)
                RX_IDLE: if (tick16 && !rxS2_q) begin
                    rxState_q <= RX_START;
                    rxTick_q <= 4'h1;
                end
                RX_START: if (tick16) begin
                    rxTick_q <= rxTick_q + 4'h1;
                    if (rxTick_q == 4'h7) begin
                        if (rxS2_q) begin
                            rxState_q <= RX_IDLE;
                        end else begin
                            rxState_q <= RX_DATA;
                            rxBit_q <= frameBits(lineCtrl_q[`LC_PAR_EN]);
                            rxTick_q <= 4'h0;
                        end
                    end
                end
                RX_DATA: if (tick16) begin
                    rxTick_q <= rxTick_q + 4'h1;
                    if (rxTick_q == 4'hF) begin
                        rxShift_q <= {rxS2_q, rxShift_q[8:1]};
                        rxBit_q <= rxBit_q - 4'h1;
                        if (rxBit_q == 4'h1) begin
                            rxState_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: if (tick16) begin
                    rxTick_q <= rxTick_q + 4'h1;
                    if (rxTick_q == 4'hF) begin
                        rxState_q <= RX_IDLE;
                        rxDone_q <= 1'b1;
                        rxPerr_q <= lineCtrl_q[`LC_PAR_EN] & ~rxParityOk;
                        rxFerr_q <= ~rxS2_q;
                    end
                end
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    // =========================================================
    // APB register access
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wrAcc = access && pwrite;
    wire rdAcc = access && !pwrite;
    wire divAccess = lineCtrl_q[`LC_DIV_ACCESS];
    wire mapped = (paddr == `OFF_DATA) || (paddr == `OFF_IRQ_EN) || (paddr == `OFF_IRQ_ID) ||
                  (paddr == `OFF_LINE_CTRL) || (paddr == `OFF_LINE_STAT) ||
                  (paddr == `OFF_MOD_STAT);
    assign busy = (txState_q != TX_IDLE) || (rxState_q != RX_IDLE) || txFull_q;
    wire lineIrq = irqEn_q[`IE_LINE] & (overrun_q | parityErr_q | frameErr_q);
    wire rxIrq = irqEn_q[`IE_RX_DATA] & dataReady_q;
    wire txIrq = irqEn_q[`IE_TX_EMPTY] & ~txFull_q;
    wire msIrq = irqEn_q[`IE_MODEM] & ctsChange_q;
    reg [3:0] pendCode;

    // Picks the highest-priority pending interrupt.
    always @* begin
        if (lineIrq) pendCode = `CODE_LINE;
        else if (rxIrq) pendCode = `CODE_RX_DATA;
        else if (txIrq) pendCode = `CODE_TX_EMPTY;
        else if (msIrq) pendCode = `CODE_MODEM;
        else if (busyWrite_q) pendCode = `CODE_BUSY;
        else pendCode = `CODE_NONE;
    end

    // One wait state: ready rises in the access phase, data latched in the setup phase.
    always @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clkEn) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (setup && !pwrite) begin
                case (paddr)
                    `OFF_DATA: prdata <= {24'h000000, divAccess ? div_q[7:0] : rxBuf_q};
                    `OFF_IRQ_EN: prdata <= {24'h000000, divAccess ? div_q[15:8] : irqEn_q};
                    `OFF_IRQ_ID: prdata <= {24'h000000, `FIFO_STAT_OFF, 2'b00, pendCode};
                    `OFF_LINE_CTRL: prdata <= {24'h000000, lineCtrl_q};
                    `OFF_LINE_STAT: prdata <= {25'h0000000, ~busy, ~txFull_q, 1'b0,
                                         frameErr_q, parityErr_q, overrun_q, dataReady_q};
                    `OFF_MOD_STAT: prdata <= {31'h00000000, busy};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes and status flags; hardware sets win over read clears.
    always @(posedge clk) begin
        if (!rstn) begin
            lineCtrl_q <= 8'h00;
            irqEn_q <= 8'h00;
            div_q <= `DIV_RESET;
            txHold_q <= 8'h00;
            txFull_q <= 1'b0;
            rxBuf_q <= 8'h00;
            dataReady_q <= 1'b0;
            overrun_q <= 1'b0;
            parityErr_q <= 1'b0;
            frameErr_q <= 1'b0;
            ctsChange_q <= 1'b0;
            busyWrite_q <= 1'b0;
            rtsN <= 1'b1;
            irqPending <= 1'b0;
        end else if (clkEn) begin
            rtsN <= dataReady_q;
            irqPending <= (pendCode != `CODE_NONE);
            if (txTake) txFull_q <= 1'b0;
            if (rdAcc && paddr == `OFF_DATA && !divAccess) dataReady_q <= 1'b0;
            if (rdAcc && paddr == `OFF_LINE_STAT) begin
                overrun_q <= 1'b0;
                parityErr_q <= 1'b0;
                frameErr_q <= 1'b0;
                ctsChange_q <= 1'b0;
            end
            if (rdAcc && paddr == `OFF_MOD_STAT) busyWrite_q <= 1'b0;
            if (ctsS2_q != ctsOld_q) ctsChange_q <= 1'b1;
            if (rxDone_q) begin
                rxBuf_q <= rxWord[7:0];
                dataReady_q <= 1'b1;
                if (dataReady_q) overrun_q <= 1'b1;
                if (rxPerr_q) parityErr_q <= 1'b1;
                if (rxFerr_q) frameErr_q <= 1'b1;
            end
            if (wrAcc) begin
                case (paddr)
                    `OFF_DATA: if (divAccess) begin
                        if (!busy) div_q[7:0] <= pwdata[7:0];
                        else busyWrite_q <= 1'b1;
                    end else if (!txFull_q) begin
                        txHold_q <= pwdata[7:0];
                        txFull_q <= 1'b1;
                    end
                    `OFF_IRQ_EN: if (divAccess) begin
                        if (!busy) div_q[15:8] <= pwdata[7:0];
                        else busyWrite_q <= 1'b1;
                    end else begin
                        irqEn_q <= {pwdata[7], 3'b000, pwdata[3:0]};
                    end
                    `OFF_LINE_CTRL: if (!busy) begin
                        lineCtrl_q <= {pwdata[7:6], 1'b0, pwdata[4:0]};
                    end else begin
                        lineCtrl_q[`LC_BREAK] <= pwdata[6];
                        busyWrite_q <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ==== verif/uart_serial_port_sva.sv ====
// Checker of the serial port's bus answers, identity reads and transmit bit timing.
`timescale 1ns/10ps
`include "uart_serial_port_defines.vh"
module uart_serial_port_sva (
    // Clock and reset.
    input wire clk,
    input wire rstn,
    // Bus.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Serial output.
    input wire txd
);
    // =====
    // Helper logic.
    reg [7:0] holdCnt_q;
    reg txdLast_q;
    wire rdDone;
    // A read that completes in this cycle.
    assign rdDone = pready && psel && penable && !pwrite;
    // Counts the cycles for which the serial output has not changed.
    always @(posedge clk) begin
        if (!rstn) begin
            holdCnt_q <= 8'h00;
            txdLast_q <= 1'b1;
        end else begin
            txdLast_q <= txd;
            if (txd != txdLast_q) begin
                holdCnt_q <= 8'h00;
            end else if (holdCnt_q != 8'hFF) begin
                holdCnt_q <= holdCnt_q + 8'h01;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // =====
    // Assertions.
    AST_READY_ONE_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready missing one cycle after the access phase began");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without a held access phase");
    AST_ERR_READ_ZERO: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error answer not paired with pready and zero data");
    AST_DATA_UPPER_ZERO: assert property (rdDone && paddr == `OFF_DATA |-> prdata[31:8] == 24'h0)
        else $error("received character read with nonzero upper bits");
    AST_ID_FIFO_OFF: assert property (rdDone && paddr == `OFF_IRQ_ID |-> prdata[31:4] == 28'h0)
        else $error("identity read shows FIFO or reserved bits set");
    AST_ID_CODE: assert property (rdDone && paddr == `OFF_IRQ_ID |->
        prdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'hC})
        else $error("identity read shows an undefined code");
    AST_TX_BIT_MIN: assert property (txd != txdLast_q |-> holdCnt_q >= 8'h0F)
        else $error("serial output changed before sixteen cycles");
endmodule
bind uart_serial_port uart_serial_port_sva uart_serial_port_sva_inst (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd));

// ==== verif/uart_remote_dev.sv ====
// Remote serial device model: framed sender, framed receiver and flow control.
`timescale 1ns/10ps
module uart_remote_dev #(parameter int BIT_CYC = 32) (
    // Clock.
    input wire clk,
    // Serial lines.
    input wire txd,
    output logic rxd,
    output logic ctsN
);
    // =====
    // The line idles high and the model is ready to take characters.
    initial begin
        rxd = 1'b1;
        ctsN = 1'b0;
    end
    // Holds off or releases the port's transmitter.
    task automatic set_cts(input logic v);
        ctsN <= v;
    endtask
    // Sends start, data LSB first, even parity, stop; badPar flips parity.
    task automatic send(input logic [7:0] b, input logic badPar);
        logic [10:0] f;
        f = {1'b1, (^b) ^ badPar, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask
    // Samples one frame mid-bit; ok falls on a bad start, stop or timeout.
    task automatic recv(output logic [8:0] got, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        ok = (n < 4000) && (txd === 1'b0);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            got[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        ok = ok && (txd === 1'b1);
    endtask
endmodule

// ==== verif/uart_serial_port_tb.sv ====
// Self-checking bench of the serial port: registers, transmit, receive and flow control.
`timescale 1ns/10ps
`include "uart_serial_port_defines.vh"
module uart_serial_port_tb;
    // =====
    // Signals.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, rxd, ctsN, txd, rtsN, irqPending;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] rdVal;
    logic rdErr;
    logic [7:0] b;
    logic [8:0] got;
    logic ok;
    // Clock of 4 ns.
    always #2 clk = ~clk;
    uart_serial_port uart_serial_port_inst (.clk(clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .ctsN(ctsN), .txd(txd), .rtsN(rtsN),
        .irqPending(irqPending));
    uart_remote_dev #(.BIT_CYC(32)) uart_remote_dev_inst (.clk(clk), .txd(txd), .rxd(rxd),
        .ctsN(ctsN));
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask
    // One bus transfer: idle edge, setup cycle, access held until pready.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdVal = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready timeout", 1, 0);
            wrap_up();
        end
    endtask
    // Reads and compares the masked value.
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdVal & m);
    endtask
    // =====
    // Main sequence.
    initial begin
        void'($urandom(38));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(`OFF_IRQ_EN, 32'hFFFFFFFF, 32'h0, "enable reset");
        rd(`OFF_IRQ_ID, 32'hFFFFFFFF, 32'h1, "identity reset");
        rd(`OFF_DATA, 32'hFFFFFFFF, 32'h0, "rx reset");
        rd(12'h010, 32'hFFFFFFFF, 32'h0, "unmapped data");
        chk("unmapped error", 1, rdErr);
        // Divisor of two: 32 clocks a bit, even parity, one stop bit.
        apb(1'b1, `OFF_LINE_CTRL, 32'h98);
        apb(1'b1, `OFF_DATA, 32'h02);
        apb(1'b1, `OFF_IRQ_EN, 32'h00);
        rd(`OFF_DATA, 32'hFFFFFFFF, 32'h02, "div low");
        rd(`OFF_IRQ_EN, 32'hFFFFFFFF, 32'h00, "div high");
        apb(1'b1, `OFF_LINE_CTRL, 32'h18);
        for (int i = 0; i < 6; i++) begin
            b = 8'($urandom);
            apb(1'b1, `OFF_IRQ_EN, {24'h0, b});
            rd(`OFF_IRQ_EN, 32'hFFFFFFFF, {24'h0, b & 8'h8F}, "enables");
        end
        // Transmit held off by flow control, then released.
        apb(1'b1, `OFF_IRQ_EN, 32'h00);
        uart_remote_dev_inst.set_cts(1'b1);
        repeat (4) @(posedge clk);
        b = 8'h5A;
        apb(1'b1, `OFF_DATA, {24'h0, b});
        repeat (300) @(posedge clk);
        chk("txd held", 1, txd);
        uart_remote_dev_inst.set_cts(1'b0);
        for (int i = 0; i < 5; i++) begin
            if (i > 0) begin
                b = (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom);
                apb(1'b1, `OFF_DATA, {24'h0, b});
            end
            uart_remote_dev_inst.recv(got, ok);
            chk("tx frame", 1, ok);
            chk("tx char", {^b, b}, got);
        end
        // Receive: good, bad parity, then with enables off.
        apb(1'b1, `OFF_IRQ_EN, 32'h05);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            if (i == 2) begin
                apb(1'b1, `OFF_IRQ_EN, 32'h00);
            end
            uart_remote_dev_inst.send(b, i == 1);
            for (int n = 0; rtsN !== 1'b1; n++) begin
                if (n == 2000) begin
                    chk("rts timeout", 1, 0);
                    wrap_up();
                end
                @(posedge clk);
            end
            chk("irq level", (i < 2), irqPending);
            rd(`OFF_IRQ_ID, 32'hFF, (i == 1) ? 32'h6 : (i == 0) ? 32'h4 : 32'h1, "identity");
            if (i == 1) begin
                rd(`OFF_LINE_STAT, 32'h05, 32'h05, "parity flag");
                rd(`OFF_IRQ_ID, 32'hFF, 32'h04, "identity after status");
            end
            rd(`OFF_DATA, 32'hFFFFFFFF, {24'h0, b}, "rx char");
            repeat (3) @(posedge clk);
            chk("rts empty", 0, rtsN);
        end
        // Transmit-empty and modem-status identities.
        apb(1'b1, `OFF_IRQ_EN, 32'h02);
        rd(`OFF_IRQ_ID, 32'hFF, 32'h2, "identity tx empty");
        uart_remote_dev_inst.set_cts(1'b1);
        repeat (8) @(posedge clk);
        uart_remote_dev_inst.set_cts(1'b0);
        repeat (8) @(posedge clk);
        apb(1'b1, `OFF_IRQ_EN, 32'h08);
        rd(`OFF_IRQ_ID, 32'hFF, 32'h0, "identity modem");
        rd(`OFF_LINE_STAT, 32'h0, 32'h0, "status clear");
        rd(`OFF_IRQ_ID, 32'hFF, 32'h1, "identity modem cleared");
        // Line control write while a frame is sent is refused as busy.
        apb(1'b1, `OFF_IRQ_EN, 32'h00);
        apb(1'b1, `OFF_DATA, 32'h33);
        apb(1'b1, `OFF_LINE_CTRL, 32'h08);
        rd(`OFF_IRQ_ID, 32'hFF, 32'h7, "identity busy");
        rd(`OFF_MOD_STAT, 32'h1, 32'h1, "module busy");
        repeat (400) @(posedge clk);
        rd(`OFF_IRQ_ID, 32'hFF, 32'h1, "identity busy cleared");
        rd(`OFF_LINE_CTRL, 32'hFF, 32'h18, "line control kept");
        // Odd parity; the clock enable freezes the port while flow control releases it.
        apb(1'b1, `OFF_LINE_CTRL, 32'h08);
        uart_remote_dev_inst.set_cts(1'b1);
        repeat (4) @(posedge clk);
        b = 8'($urandom);
        apb(1'b1, `OFF_DATA, {24'h0, b});
        clkEn <= 1'b0;
        uart_remote_dev_inst.set_cts(1'b0);
        repeat (200) @(posedge clk);
        chk("txd frozen", 1, txd);
        clkEn <= 1'b1;
        uart_remote_dev_inst.recv(got, ok);
        chk("odd frame", 1, ok);
        chk("odd char", {~^b, b}, got);
        wrap_up();
    end
endmodule
